// ### shared/scr_map.svh
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// Register addresses on the 13-bit serial address space
`define SCR_ADDR_CFG 13'h0000
`define SCR_ADDR_UNUSED1 13'h0001
`define SCR_ADDR_RSVD2 13'h0002
`define SCR_ADDR_PART_IDENTIFICATION 13'h0003
`define SCR_ADDR_READBACK 13'h0004
`define SCR_ADDR_CV_LO 13'h0005
`define SCR_ADDR_CV_HI 13'h0006
`define SCR_ADDR_UNUSED_LO 13'h0007
`define SCR_ADDR_UNUSED_HI 13'h000f
`define SCR_ADDR_CP 13'h0010
`define SCR_ADDR_RDIV_LO 13'h0011
`define SCR_ADDR_RDIV_HI 13'h0012

// Serial port configuration field positions (mirrored halves)
`define SCR_CFG_SDO_HI 7
`define SCR_CFG_LSB_HI 6
`define SCR_CFG_SRST_HI 5
`define SCR_CFG_SRST_LO 2
`define SCR_CFG_LSB_LO 1
`define SCR_CFG_SDO_LO 0

`define SCR_RB_ACTIVE_BIT 0
`define SCR_RDIV_HI_W 6

// Reset values
`define SCR_RST_BYTE 8'h00
`define SCR_RST_CP 8'h7d
`define SCR_RST_RDIV 14'h0001

// Serial framing
`define SCR_INSTR_LAST 4'hf
`define SCR_BYTE_LAST 3'h7
`define SCR_STREAM 2'h3

`endif

// ### shared/scr_pkg.sv
package scr_pkg;

  typedef enum logic [1:0] {SCR_INSTR, SCR_DATA, SCR_DONE} scr_phase_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [2:0] sdi_s;
    logic cs_lvl;
    logic sck_lvl;
    scr_phase_t phase;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic rd;
    logic [1:0] wcnt;
    logic [1:0] bcnt;
    logic [12:0] addr;
    logic [7:0] osh;
    logic dout;
    logic wr;
    logic [7:0] wdata;
    logic [12:0] waddr;
  } scr_spi_t;

  typedef struct packed {
    logic [7:0] cv_lo;
    logic [7:0] cv_hi;
    logic [7:0] cp;
    logic [13:0] rdiv;
  } scr_bank_t;

  typedef struct packed {
    logic sdo;
    logic lsb;
    logic rb_act;
    scr_bank_t bufr;
    scr_bank_t act;
  } scr_regs_t;

endpackage

// ### rtl/scr_spi_port.sv
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_spi_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic sdio_in,
  input wire logic cfg_sdo,
  input wire logic cfg_lsb,
  input wire logic [7:0] rd_data,
  output logic [12:0] acc_addr,
  output logic wr_valid,
  output logic [12:0] wr_addr,
  output logic [7:0] wr_data,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo_out,
  output logic sdo_oe
);

  scr_pkg::scr_spi_t s_ff;
  scr_pkg::scr_spi_t nxt_s;
  logic drive;

  always_comb begin
    logic rise;
    logic fall;
    logic [15:0] shin;
    logic [15:0] instr;
    logic [7:0] byte_in;
    logic [7:0] ob;
    logic [15:0] rev16;
    logic [7:0] rev8;
    rise = 1'b0;
    fall = 1'b0;
    shin = 16'h0000;
    instr = 16'h0000;
    byte_in = 8'h00;
    ob = 8'h00;
    rev16 = 16'h0000;
    rev8 = 8'h00;
    nxt_s = s_ff;
    nxt_s.wr = 1'b0;
    // Three-stage sync; a level counts once stages two and three agree
    nxt_s.cs_s = {s_ff.cs_s[1:0], spi_cs_n};
    nxt_s.sck_s = {s_ff.sck_s[1:0], spi_sclk};
    nxt_s.sdi_s = {s_ff.sdi_s[1:0], sdio_in};
    if (s_ff.cs_s[1] == s_ff.cs_s[2]) begin
      nxt_s.cs_lvl = s_ff.cs_s[2];
    end
    if (s_ff.sck_s[1] == s_ff.sck_s[2]) begin
      nxt_s.sck_lvl = s_ff.sck_s[2];
      rise = s_ff.sck_s[2] && !s_ff.sck_lvl && !s_ff.cs_lvl;
      fall = !s_ff.sck_s[2] && s_ff.sck_lvl && !s_ff.cs_lvl;
    end
    if (s_ff.cs_lvl) begin
      nxt_s.phase = scr_pkg::SCR_INSTR;
      nxt_s.cnt = 4'h0;
      nxt_s.bcnt = 2'h0;
      nxt_s.rd = 1'b0;
      nxt_s.dout = 1'b0;
    end else if (rise) begin
      shin = {s_ff.sh[14:0], s_ff.sdi_s[2]};
      nxt_s.sh = shin;
      nxt_s.cnt = s_ff.cnt + 4'h1;
      unique case (s_ff.phase)
        scr_pkg::SCR_INSTR: begin
          if (s_ff.cnt == `SCR_INSTR_LAST) begin
            rev16 = {<<{shin}};
            instr = cfg_lsb ? rev16 : shin;
            nxt_s.rd = instr[15];
            nxt_s.wcnt = instr[14:13];
            nxt_s.addr = instr[12:0];
            nxt_s.phase = scr_pkg::SCR_DATA;
            nxt_s.cnt = 4'h0;
          end
        end
        scr_pkg::SCR_DATA: begin
          if (s_ff.cnt[2:0] == `SCR_BYTE_LAST) begin
            rev8 = {<<{shin[7:0]}};
            byte_in = cfg_lsb ? rev8 : shin[7:0];
            nxt_s.cnt = 4'h0;
            if (!s_ff.rd) begin
              nxt_s.wr = 1'b1;
              nxt_s.wdata = byte_in;
              nxt_s.waddr = s_ff.addr;
            end
            // Address walks up in LSB-first mode, down otherwise
            nxt_s.addr = cfg_lsb ? s_ff.addr + 13'h0001
                                 : s_ff.addr - 13'h0001;
            nxt_s.bcnt = s_ff.bcnt + 2'h1;
            if (s_ff.wcnt != `SCR_STREAM && s_ff.bcnt == s_ff.wcnt) begin
              nxt_s.phase = scr_pkg::SCR_DONE;
            end
          end
        end
        scr_pkg::SCR_DONE: begin
        end
      endcase
    end else if (fall && s_ff.rd && s_ff.phase == scr_pkg::SCR_DATA) begin
      if (s_ff.cnt == 4'h0) begin
        // Byte fetched at the first falling edge so a write just made shows
        rev8 = {<<{rd_data}};
        ob = cfg_lsb ? rev8 : rd_data;
        nxt_s.dout = ob[7];
        nxt_s.osh = {ob[6:0], 1'b0};
      end else begin
        nxt_s.dout = s_ff.osh[7];
        nxt_s.osh = {s_ff.osh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '{cs_s: 3'h7, cs_lvl: 1'b1, phase: scr_pkg::SCR_INSTR,
                default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign drive = !s_ff.cs_lvl && s_ff.rd && s_ff.phase == scr_pkg::SCR_DATA;
  assign acc_addr = s_ff.addr;
  assign wr_valid = s_ff.wr;
  assign wr_addr = s_ff.waddr;
  assign wr_data = s_ff.wdata;
  assign sdio_out = s_ff.dout;
  assign sdo_out = s_ff.dout;
  assign sdio_oe = drive && !cfg_sdo;
  assign sdo_oe = drive && cfg_sdo;

endmodule // scr_spi_port

// ### rtl/scr_regs.sv
`timescale 1ns/1ps
`include "scr_map.svh"

// Overview of operation
// - Writes to addresses outside the map change nothing.
// - Writes to unused addresses 0x007 to 0x00F change nothing.
// - Readback bit 0 at 0x004 picks active over buffered values; resets 0.
// - Reference divider is 14 bits: low byte, then six bits below two unused.
module scr_regs #(
  // Value is arbitrary
  parameter logic [7:0] PART_IDENTIFICATION = 8'h5a
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic update_strobe,
  output logic [7:0] charge_pump_cfg,
  output logic [13:0] ref_divider,
  output logic [15:0] customer_version
);

  localparam scr_pkg::scr_bank_t BANK_RST = '{
    cv_lo: `SCR_RST_BYTE, cv_hi: `SCR_RST_BYTE,
    cp: `SCR_RST_CP, rdiv: `SCR_RST_RDIV};
  localparam scr_pkg::scr_regs_t REGS_RST = '{
    sdo: 1'b0, lsb: 1'b0, rb_act: 1'b0, bufr: BANK_RST, act: BANK_RST};

  scr_pkg::scr_regs_t s_ff;
  scr_pkg::scr_regs_t nxt_s;
  scr_pkg::scr_bank_t view;
  logic [12:0] acc_addr;
  logic wr_valid;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  scr_spi_port u_port (
    .clk(clk),
    .resetn(resetn),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .sdio_in(sdio_in),
    .cfg_sdo(s_ff.sdo),
    .cfg_lsb(s_ff.lsb),
    .rd_data(rd_data),
    .acc_addr(acc_addr),
    .wr_valid(wr_valid),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .sdo_out(sdo_out),
    .sdo_oe(sdo_oe)
  );

  always_comb begin
    nxt_s = s_ff;
    // Transfer buffered settings to the active bank
    if (update_strobe) begin
      nxt_s.act = s_ff.bufr;
    end
    if (wr_valid) begin
      // Only decoded addresses store; all others fall through untouched
      case (wr_addr)
        `SCR_ADDR_CFG: begin
          if (wr_data[`SCR_CFG_SRST_HI] || wr_data[`SCR_CFG_SRST_LO]) begin
            // Bit itself is never stored, so it reads back as zero
            nxt_s = REGS_RST;
          end else begin
            nxt_s.sdo = wr_data[`SCR_CFG_SDO_HI] | wr_data[`SCR_CFG_SDO_LO];
            nxt_s.lsb = wr_data[`SCR_CFG_LSB_HI] | wr_data[`SCR_CFG_LSB_LO];
          end
        end
        `SCR_ADDR_READBACK: begin
          nxt_s.rb_act = wr_data[`SCR_RB_ACTIVE_BIT];
        end
        `SCR_ADDR_CV_LO: begin
          nxt_s.bufr.cv_lo = wr_data;
        end
        `SCR_ADDR_CV_HI: begin
          nxt_s.bufr.cv_hi = wr_data;
        end
        `SCR_ADDR_CP: begin
          nxt_s.bufr.cp = wr_data;
        end
        `SCR_ADDR_RDIV_LO: begin
          nxt_s.bufr.rdiv[7:0] = wr_data;
        end
        `SCR_ADDR_RDIV_HI: begin
          nxt_s.bufr.rdiv[13:8] = wr_data[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= REGS_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign view = s_ff.rb_act ? s_ff.act : s_ff.bufr;

  always_comb begin
    rd_data = 8'h00;
    case (acc_addr)
      `SCR_ADDR_CFG: begin
        rd_data = {s_ff.sdo, s_ff.lsb, 4'h0, s_ff.lsb, s_ff.sdo};
      end
      `SCR_ADDR_PART_IDENTIFICATION: begin
        rd_data = PART_IDENTIFICATION;
      end
      `SCR_ADDR_READBACK: begin
        rd_data = {7'h00, s_ff.rb_act};
      end
      `SCR_ADDR_CV_LO: begin
        rd_data = view.cv_lo;
      end
      `SCR_ADDR_CV_HI: begin
        rd_data = view.cv_hi;
      end
      `SCR_ADDR_CP: begin
        rd_data = view.cp;
      end
      `SCR_ADDR_RDIV_LO: begin
        rd_data = view.rdiv[7:0];
      end
      `SCR_ADDR_RDIV_HI: begin
        rd_data = {2'b00, view.rdiv[13:8]};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  assign charge_pump_cfg = s_ff.act.cp;
  assign ref_divider = s_ff.act.rdiv;
  assign customer_version = {s_ff.act.cv_hi, s_ff.act.cv_lo};

  logic mapped;
  assign mapped = wr_addr inside {`SCR_ADDR_CFG, `SCR_ADDR_READBACK,
    `SCR_ADDR_CV_LO, `SCR_ADDR_CV_HI, `SCR_ADDR_CP, `SCR_ADDR_RDIV_LO,
    `SCR_ADDR_RDIV_HI};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence sr_write_s;
    wr_valid && wr_addr == `SCR_ADDR_CFG &&
      (wr_data[`SCR_CFG_SRST_HI] || wr_data[`SCR_CFG_SRST_LO]);
  endsequence

  sequence bank_cleared_s;
    s_ff == REGS_RST ##0 customer_version == 16'h0000;
  endsequence

  unmapped_write_a: assert property (
    wr_valid && !mapped && !update_strobe |=> s_ff == $past(s_ff))
    else $error("unmapped write changed state");

  unused_block_a: assert property (
    wr_valid && wr_addr >= `SCR_ADDR_UNUSED_LO &&
    wr_addr <= `SCR_ADDR_UNUSED_HI && !update_strobe
    |=> $stable(s_ff.bufr) && $stable(s_ff.act) && $stable(s_ff.rb_act))
    else $error("write to unused block changed state");

  // Active view must match what the outputs carry, not the buffer
  readback_sel_a: assert property (
    acc_addr == `SCR_ADDR_CV_LO && s_ff.rb_act |->
      rd_data == customer_version[7:0])
    else $error("readback source wrong");

  rdiv_split_a: assert property (
    wr_valid && wr_addr == `SCR_ADDR_RDIV_HI
    |=> s_ff.bufr.rdiv[13:8] == $past(wr_data[5:0]) &&
        s_ff.bufr.rdiv[7:0] == $past(s_ff.bufr.rdiv[7:0]))
    else $error("divider high byte not stored in bits 13:8");

  version_store_a: assert property (
    wr_valid && wr_addr == `SCR_ADDR_CV_LO && !update_strobe
    |=> s_ff.bufr.cv_lo == $past(wr_data) && $stable(customer_version))
    else $error("customer version low byte lost");

  version_update_a: assert property (
    update_strobe && !wr_valid |=>
      customer_version == $past({s_ff.bufr.cv_hi, s_ff.bufr.cv_lo}))
    else $error("customer version not taken on update");

  soft_reset_a: assert property (
    sr_write_s |=> bank_cleared_s)
    else $error("soft reset did not clear bank");

  soft_clear_a: assert property (
    acc_addr == `SCR_ADDR_CFG |-> rd_data[5] == 1'b0 && rd_data[2] == 1'b0)
    else $error("soft reset bit did not self-clear");

endmodule // scr_regs

// ### tb/scr_host_model.sv
`timescale 1ns/1ps

// Serial host: either bit order, three- or four-wire readback
module scr_host_model (
  input wire logic clk,
  input wire logic sdio_wire,
  input wire logic sdo_wire,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic host_d,
  output logic rd_done,
  output logic [7:0] rd_byte
);
  // Six clocks per half period leaves margin over the pin synchronisers
  localparam int HALF = 6;

  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    host_d = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic xfer(input logic rd, input logic [1:0] w,
                      input logic [12:0] a, input logic [15:0] d,
                      input logic lsb, input logic four);
    logic [15:0] ins;
    int n;
    int j;
    ins = {rd, w, a};
    // Writes carry up to two bytes, first byte in d[7:0]; reads carry one
    n = 24 + 8 * w;
    gap(1);
    spi_cs_n = 1'b0;
    gap(HALF);
    for (int k = 0; k < n; k++) begin
      if (k < 16) j = lsb ? k : 15 - k;
      else j = 8 * ((k - 16) / 8) + (lsb ? k % 8 : 7 - k % 8);
      // Released line toggles so a stale level cannot pass for data
      if (k < 16) host_d = ins[j];
      else if (!rd) host_d = d[j];
      else host_d = ~host_d;
      gap(HALF);
      spi_sclk = 1'b1;
      if (rd && k >= 16) rd_byte[j] = four ? sdo_wire : sdio_wire;
      gap(HALF);
      spi_sclk = 1'b0;
    end
    gap(HALF);
    spi_cs_n = 1'b1;
    host_d = ~host_d;
    gap(2 * HALF);
    if (rd) begin
      rd_done = 1'b1;
      gap(1);
      rd_done = 1'b0;
    end
  endtask
endmodule // scr_host_model

// ### tb/scr_regs_tb.sv
`timescale 1ns/1ps

module scr_regs_tb;
  // Value is arbitrary
  localparam logic [7:0] ID = 8'h3c;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic update_strobe = 1'b0;
  logic spi_cs_n, spi_sclk, host_d, rd_done, sdio_wire, sdo_wire;
  logic lsb_m = 1'b0;
  logic four_m = 1'b0;
  logic sdio_out, sdio_oe, sdo_out, sdo_oe;
  logic [7:0] rd_byte, charge_pump_cfg;
  logic [13:0] ref_divider;
  logic [15:0] customer_version;
  logic [7:0] exp_q[$];
  logic [7:0] v[5];
  logic [12:0] ra[8] = '{13'h0, 13'h3, 13'h4, 13'h5, 13'h6, 13'h10,
                         13'h11, 13'h12};
  logic [7:0] re[8] = '{8'h00, ID, 8'h00, 8'h00, 8'h00, 8'h7d, 8'h01,
                        8'h00};
  logic [12:0] wa[5] = '{13'h5, 13'h6, 13'h10, 13'h11, 13'h12};
  logic [12:0] ua[7] = '{13'h1, 13'h2, 13'h3, 13'h7, 13'ha, 13'hf, 13'h1ff};
  logic [7:0] sr[2] = '{8'h20, 8'h04};
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;
  assign sdio_wire = sdio_oe ? sdio_out : host_d;
  // Released SDO floats to its pull-up
  assign sdo_wire = sdo_oe ? sdo_out : 1'b1;

  scr_regs #(.PART_IDENTIFICATION(ID)) u_scr_regs (
    .clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .update_strobe(update_strobe),
    .charge_pump_cfg(charge_pump_cfg), .ref_divider(ref_divider),
    .customer_version(customer_version)
  );

  scr_host_model u_scr_host_model (
    .clk(clk), .sdio_wire(sdio_wire), .sdo_wire(sdo_wire),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .host_d(host_d), .rd_done(rd_done),
    .rd_byte(rd_byte)
  );

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_scr_host_model.xfer(1'b0, 2'b00, a, {8'h00, d}, lsb_m, four_m);
  endtask

  task automatic wr2(input logic [12:0] a, input logic [15:0] d);
    u_scr_host_model.xfer(1'b0, 2'b01, a, d, lsb_m, four_m);
  endtask

  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_scr_host_model.xfer(1'b1, 2'b00, a, 16'h0000, lsb_m, four_m);
  endtask

  task automatic outs(input logic [7:0] cp, input logic [13:0] rdv,
                      input logic [15:0] cv);
    chk({8'h00, charge_pump_cfg}, {8'h00, cp}, "charge pump");
    chk({2'b00, ref_divider}, {2'b00, rdv}, "divider");
    chk(customer_version, cv, "version");
  endtask

  task automatic upd();
    @(negedge clk);
    update_strobe = 1'b1;
    @(negedge clk);
    update_strobe = 1'b0;
  endtask

  task automatic bank();
    foreach (wa[i]) rd(wa[i], i == 4 ? {2'b00, v[4][5:0]} : v[i]);
  endtask

  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0, 16'h1, "unexpected read");
      else chk({8'h00, rd_byte}, {8'h00, exp_q.pop_front()}, "read data");
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      chk(16'h0, 16'h1, "timeout");
      wrap_up();
    end
  end

  initial begin
    void'($urandom(34));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    outs(8'h7d, 14'h0001, 16'h0000);
    foreach (ra[i]) rd(ra[i], re[i]);
    foreach (v[i]) v[i] = 8'($urandom());
    v[4][7:6] = 2'b11;
    foreach (wa[i]) wr(wa[i], v[i]);
    bank();
    // Buffered bytes must not reach the outputs before the update
    outs(8'h7d, 14'h0001, 16'h0000);
    upd();
    outs(v[2], {v[4][5:0], v[3]}, {v[1], v[0]});
    foreach (ua[i]) wr(ua[i], 8'hff);
    foreach (ua[i]) rd(ua[i], ua[i] == 13'h3 ? ID : 8'h00);
    rd(13'h000, 8'h00);
    rd(13'h004, 8'h00);
    bank();
    upd();
    outs(v[2], {v[4][5:0], v[3]}, {v[1], v[0]});
    wr(13'h004, 8'h01);
    wr(13'h005, ~v[0]);
    rd(13'h004, 8'h01);
    rd(13'h005, v[0]);
    wr(13'h004, 8'h00);
    rd(13'h005, ~v[0]);
    foreach (sr[i]) begin
      wr(13'h010, 8'h11);
      wr(13'h004, 8'h01);
      upd();
      wr(13'h000, sr[i]);
      rd(13'h000, 8'h00);
      outs(8'h7d, 14'h0001, 16'h0000);
      foreach (ra[j]) rd(ra[j], re[j]);
    end
    // Four-wire readback on SDO, then LSB-first framing, two-byte writes
    wr(13'h000, 8'h81);
    four_m = 1'b1;
    rd(13'h000, 8'h81);
    rd(13'h003, ID);
    wr2(13'h006, {v[0], v[1]});
    rd(13'h006, v[1]);
    rd(13'h005, v[0]);
    wr(13'h000, 8'h42);
    four_m = 1'b0;
    lsb_m = 1'b1;
    rd(13'h000, 8'h42);
    wr2(13'h011, {v[4], v[3]});
    rd(13'h011, v[3]);
    rd(13'h012, {2'b00, v[4][5:0]});
    upd();
    outs(8'h7d, {v[4][5:0], v[3]}, {v[1], v[0]});
    // Mid-run hardware reset returns bank and port to MSB-first defaults
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    lsb_m = 1'b0;
    repeat (4) @(negedge clk);
    outs(8'h7d, 14'h0001, 16'h0000);
    rd(13'h000, 8'h00);
    rd(13'h012, 8'h00);
    repeat (20) @(negedge clk);
    wrap_up();
  end
endmodule // scr_regs_tb
